// ---- logic/bscr_regs.sv ----
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/100ps
// Overview of operation
// - Bits 23:16 of word 18h are a read-write subordinate bus number, reset to zero.
// - Bits 31:24 of word 18h are a read-write secondary latency count, reset to zero.
// - With latency zero and grant removed, master cycles end after the first data phase, except MWI.
// - Bits 3:0 and 11:8 of word 1Ch read as one, showing 32-bit I/O addressing.
// - Bits 7:4 are writable I/O base address bits 15:12, low bits taken as zero, reset zero.
// - Bits 15:12 are writable I/O limit address bits 15:12, low bits taken as FFFh, reset zero.
// - Status bit 21 reads one for 66 MHz capability; bits 20:16 and 22 read zero.
// - Status bit 23 reads one for fast back-to-back decode on the secondary side.
// - Status bit 24 sets when the secondary parity pin is low and command bit 6 is set.
// - Status bits 26:25 read binary 01 for medium select decode speed.
// - Status bit 27 sets when the bridge as secondary target signals target abort.
// - Status bit 28 sets when a secondary cycle the bridge mastered gets target abort.
// - Status bit 29 sets when a secondary cycle the bridge mastered ends in master abort.
// - Status bit 30 sets when the secondary system error pin is seen low.
// - Status bit 31 sets on an address or data parity error on the secondary side.
module bscr_regs (
    input wire logic i_mclk,
    input wire logic i_rstn,
    // AXI4-Lite slave
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [7:0] i_awaddr,
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    input wire logic i_arvalid,
    output logic o_arready,
    input wire logic [7:0] i_araddr,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    // Secondary bus events
    input wire logic i_secondary_parity_error_pin_n,
    input wire logic i_secondary_system_error_pin_n,
    input wire logic i_target_abort_signaled,
    input wire logic i_target_abort_received,
    input wire logic i_master_abort_received,
    input wire logic i_parity_error_detected,
    // Secondary master cycle
    input wire logic i_frame_start,
    input wire logic i_frame_active,
    input wire logic i_sec_gnt_n,
    input wire logic i_data_done,
    input wire logic i_mwi,
    output logic o_lat_expired,
    output logic o_master_stop,
    // I/O window decode
    input wire logic i_io_valid,
    input wire logic [31:0] i_io_addr,
    output logic o_io_forward,
    // Configuration and interrupt
    output logic [7:0] o_subordinate_bus,
    output logic o_irq
);
    // ----------------------------------------------------------------
    // Configuration state
    // ----------------------------------------------------------------
    logic [7:0] sub_bus_r;
    logic [7:0] lat_r;
    logic [3:0] io_base_r;
    logic [3:0] io_lim_r;
    logic [15:0] io_base_up_r;
    logic [15:0] io_lim_up_r;
    logic perr_en_r;
    logic [5:0] irq_mask_r;
    logic io_fwd_r;

    // ----------------------------------------------------------------
    // Bus handshake state
    // ----------------------------------------------------------------
    logic aw_hold_r;
    logic w_hold_r;
    logic [7:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;

    // ----------------------------------------------------------------
    // Write path decode
    // ----------------------------------------------------------------
    wire aw_take = i_awvalid && o_awready;
    wire w_take = i_wvalid && o_wready;
    wire wr_go = aw_hold_r && w_hold_r && !bvalid_r;
    wire wr_bus_lat = wr_go && (awaddr_r == bscr_pkg::OFS_BUS_LAT);
    wire wr_io_sts = wr_go && (awaddr_r == bscr_pkg::OFS_IO_STS);
    wire wr_irq_sts = wr_go && (awaddr_r == bscr_pkg::OFS_IRQ_STS);
    wire wr_mask = wr_go && (awaddr_r == bscr_pkg::OFS_IRQ_MASK);
    wire wr_ctrl = wr_go && (awaddr_r == bscr_pkg::OFS_CTRL);
    wire wr_upper = wr_go && (awaddr_r == bscr_pkg::OFS_IO_UPPER);
    wire wr_hit = wr_bus_lat || wr_io_sts || wr_irq_sts ||
                  wr_mask || wr_ctrl || wr_upper;

    // Holding both channels lets the master present them in either order
    assign o_awready = !aw_hold_r && !bvalid_r;
    assign o_wready = !w_hold_r && !bvalid_r;
    assign o_bvalid = bvalid_r;
    assign o_bresp = bresp_r;

    // ----------------------------------------------------------------
    // Read path decode
    // ----------------------------------------------------------------
    wire ar_take = i_arvalid && o_arready;
    wire rd_bus_lat = (i_araddr == bscr_pkg::OFS_BUS_LAT);
    wire rd_io_sts = (i_araddr == bscr_pkg::OFS_IO_STS);
    wire rd_irq_sts = (i_araddr == bscr_pkg::OFS_IRQ_STS);
    wire rd_mask = (i_araddr == bscr_pkg::OFS_IRQ_MASK);
    wire rd_ctrl = (i_araddr == bscr_pkg::OFS_CTRL);
    wire rd_upper = (i_araddr == bscr_pkg::OFS_IO_UPPER);
    wire rd_hit = rd_bus_lat || rd_io_sts || rd_irq_sts ||
                  rd_mask || rd_ctrl || rd_upper;

    assign o_arready = !rvalid_r;
    assign o_rvalid = rvalid_r;
    assign o_rdata = rdata_r;
    assign o_rresp = rresp_r;

    // ----------------------------------------------------------------
    // Sticky event flags
    // ----------------------------------------------------------------
    // Event order: dpe, sig tabort, rcv tabort, rcv mabort, serr, parity
    logic [5:0] ev;
    logic [5:0] sts;
    logic [5:0] sts_clr;
    logic [5:0] irq_sts;
    logic [5:0] irq_clr;

    assign ev[0] = !i_secondary_parity_error_pin_n && perr_en_r;
    assign ev[1] = i_target_abort_signaled;
    assign ev[2] = i_target_abort_received;
    assign ev[3] = i_master_abort_received;
    assign ev[4] = !i_secondary_system_error_pin_n;
    assign ev[5] = i_parity_error_detected;

    // Only the top byte lane reaches the flags
    assign sts_clr = (wr_io_sts && wstrb_r[3]) ?
                     {wdata_r[31:bscr_pkg::ST_STA], wdata_r[bscr_pkg::ST_DPE]} :
                     bscr_pkg::EV_RST;

    // Interrupt copy is cleared by reading it, so a poll loses nothing
    assign irq_clr = (ar_take && rd_irq_sts) ? ~bscr_pkg::EV_RST : bscr_pkg::EV_RST;

    bscr_flags #(
        .W(bscr_pkg::NUM_EV)
    ) u_sts (
        .i_mclk(i_mclk),
        .i_rstn(i_rstn),
        .i_set(ev),
        .i_clr(sts_clr),
        .o_q(sts)
    );

    bscr_flags #(
        .W(bscr_pkg::NUM_EV)
    ) u_irq (
        .i_mclk(i_mclk),
        .i_rstn(i_rstn),
        .i_set(ev),
        .i_clr(irq_clr),
        .o_q(irq_sts)
    );

    assign o_irq = |(irq_sts & irq_mask_r);

    // ----------------------------------------------------------------
    // Read words
    // ----------------------------------------------------------------
    wire [31:0] word_bus_lat = {lat_r, sub_bus_r, 16'h0000};
    wire [15:0] word_io = {io_lim_r, bscr_pkg::IO32_IND,
                           io_base_r, bscr_pkg::IO32_IND};
    wire [15:0] word_sts = {sts[5:1],
                            bscr_pkg::SEL_SPEED,
                            sts[0],
                            bscr_pkg::ST_FBB,
                            bscr_pkg::ST_RSVD_22,
                            bscr_pkg::ST_66MHZ,
                            bscr_pkg::ST_RSVD_LO};
    wire [31:0] word_ctrl = {25'h0000000, perr_en_r, 6'h00};
    wire [31:0] word_upper = {io_lim_up_r, io_base_up_r};
    wire [31:0] rd_word = rd_bus_lat ? word_bus_lat :
                          rd_io_sts ? {word_sts, word_io} :
                          rd_irq_sts ? {26'h0000000, irq_sts} :
                          rd_mask ? {26'h0000000, irq_mask_r} :
                          rd_ctrl ? word_ctrl :
                          rd_upper ? word_upper :
                          bscr_pkg::WORD_RST;

    // ----------------------------------------------------------------
    // I/O window decode
    // ----------------------------------------------------------------
    wire [31:0] io_lo = {io_base_up_r, io_base_r, bscr_pkg::IO_BASE_LOW};
    wire [31:0] io_hi = {io_lim_up_r, io_lim_r, bscr_pkg::IO_LIM_LOW};
    wire io_hit = i_io_valid && (i_io_addr >= io_lo) && (i_io_addr <= io_hi);

    assign o_io_forward = io_fwd_r;
    assign o_subordinate_bus = sub_bus_r;

    // ----------------------------------------------------------------
    // Latency timer
    // ----------------------------------------------------------------
    bscr_lat_timer u_lat (
        .i_mclk(i_mclk),
        .i_rstn(i_rstn),
        .i_lat(lat_r),
        .i_frame_start(i_frame_start),
        .i_frame_active(i_frame_active),
        .i_gnt_n(i_sec_gnt_n),
        .i_data_done(i_data_done),
        .i_mwi(i_mwi),
        .o_expired(o_lat_expired),
        .o_stop(o_master_stop)
    );

    // ----------------------------------------------------------------
    // Write channel capture and response
    // ----------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            aw_hold_r <= 1'b0;
            awaddr_r <= 8'h00;
        end else if (aw_take) begin
            aw_hold_r <= 1'b1;
            awaddr_r <= i_awaddr;
        end else if (wr_go) begin
            aw_hold_r <= 1'b0;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            w_hold_r <= 1'b0;
            wdata_r <= bscr_pkg::WORD_RST;
            wstrb_r <= 4'h0;
        end else if (w_take) begin
            w_hold_r <= 1'b1;
            wdata_r <= i_wdata;
            wstrb_r <= i_wstrb;
        end else if (wr_go) begin
            w_hold_r <= 1'b0;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            bvalid_r <= 1'b0;
            bresp_r <= bscr_pkg::RESP_OKAY;
        end else if (wr_go) begin
            bvalid_r <= 1'b1;
            bresp_r <= wr_hit ? bscr_pkg::RESP_OKAY : bscr_pkg::RESP_SLVERR;
        end else if (i_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Read response
    // ----------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            rvalid_r <= 1'b0;
            rdata_r <= bscr_pkg::WORD_RST;
            rresp_r <= bscr_pkg::RESP_OKAY;
        end else if (ar_take) begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_word;
            rresp_r <= rd_hit ? bscr_pkg::RESP_OKAY : bscr_pkg::RESP_SLVERR;
        end else if (i_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Writable configuration fields
    // ----------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            sub_bus_r <= bscr_pkg::BYTE_RST;
            lat_r <= bscr_pkg::BYTE_RST;
        end else if (wr_bus_lat) begin
            if (wstrb_r[2]) begin
                sub_bus_r <= wdata_r[bscr_pkg::SUB_LSB +: 8];
            end
            if (wstrb_r[3]) begin
                lat_r <= wdata_r[bscr_pkg::LAT_LSB +: 8];
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            io_base_r <= bscr_pkg::NIB_RST;
            io_lim_r <= bscr_pkg::NIB_RST;
        end else if (wr_io_sts) begin
            if (wstrb_r[0]) begin
                io_base_r <= wdata_r[bscr_pkg::IO_BASE_LSB +: 4];
            end
            if (wstrb_r[1]) begin
                io_lim_r <= wdata_r[bscr_pkg::IO_LIM_LSB +: 4];
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            io_base_up_r <= 16'h0000;
            io_lim_up_r <= 16'h0000;
        end else if (wr_upper) begin
            if (&wstrb_r[1:0]) begin
                io_base_up_r <= wdata_r[15:0];
            end
            if (&wstrb_r[3:2]) begin
                io_lim_up_r <= wdata_r[bscr_pkg::UP_LIM_LSB +: 16];
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            perr_en_r <= 1'b0;
            irq_mask_r <= bscr_pkg::EV_RST;
        end else begin
            if (wr_ctrl && wstrb_r[0]) begin
                perr_en_r <= wdata_r[bscr_pkg::CTRL_PERR_EN];
            end
            if (wr_mask && wstrb_r[0]) begin
                irq_mask_r <= wdata_r[5:0];
            end
        end
    end

    // Registered so the forward decision is a clean flop output
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            io_fwd_r <= 1'b0;
        end else begin
            io_fwd_r <= io_hit;
        end
    end
endmodule

// ---- logic/bscr_pkg.sv ----
package bscr_pkg;
    // ----------------------------------------------------------------
    // Register byte addresses
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_BUS_LAT = 8'h18;
    localparam logic [7:0] OFS_IO_STS = 8'h1c;
    localparam logic [7:0] OFS_IRQ_STS = 8'h40;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h44;
    localparam logic [7:0] OFS_CTRL = 8'h48;
    localparam logic [7:0] OFS_IO_UPPER = 8'h4c;
    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int SUB_LSB = 16;
    localparam int LAT_LSB = 24;
    localparam int IO_BASE_LSB = 4;
    localparam int IO_LIM_LSB = 12;
    localparam int CTRL_PERR_EN = 6;
    localparam int ST_DPE = 24;
    localparam int ST_STA = 27;
    localparam int UP_LIM_LSB = 16;
    localparam int NUM_EV = 6;
    // ----------------------------------------------------------------
    // Reset and fixed values
    // ----------------------------------------------------------------
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [3:0] NIB_RST = 4'h0;
    localparam logic [3:0] IO32_IND = 4'h1;
    localparam logic [4:0] ST_RSVD_LO = 5'h00;
    localparam logic ST_66MHZ = 1'b1;
    localparam logic ST_RSVD_22 = 1'b0;
    localparam logic ST_FBB = 1'b1;
    localparam logic [1:0] SEL_SPEED = 2'h1;
    localparam logic [11:0] IO_BASE_LOW = 12'h000;
    localparam logic [11:0] IO_LIM_LOW = 12'hfff;
    localparam logic [5:0] EV_RST = 6'h00;
    localparam logic [31:0] WORD_RST = 32'h0000_0000;
    // ----------------------------------------------------------------
    // Bus answers
    // ----------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- logic/bscr_flags.sv ----
`timescale 1ns/100ps
// Bank of sticky flags; a set in the cycle of a clear wins
module bscr_flags #(
    parameter int W = 6
) (
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic [W-1:0] i_set,
    input wire logic [W-1:0] i_clr,
    output logic [W-1:0] o_q
);
    logic [W-1:0] q_r;
    logic [W-1:0] q_nxt;

    assign q_nxt = i_set | (q_r & ~i_clr);
    assign o_q = q_r;

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end
endmodule

// ---- logic/bscr_lat_timer.sv ----
`timescale 1ns/100ps
// Secondary master latency timer, counts i_mclk periods from frame start
module bscr_lat_timer (
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic [7:0] i_lat,
    input wire logic i_frame_start,
    input wire logic i_frame_active,
    input wire logic i_gnt_n,
    input wire logic i_data_done,
    input wire logic i_mwi,
    output logic o_expired,
    output logic o_stop
);
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    logic run_r;
    logic first_r;
    logic zero_lat;
    logic first_seen;

    assign zero_lat = (i_lat == 8'h00);
    assign cnt_nxt = i_frame_start ? i_lat :
                     (run_r && cnt_r != 8'h00) ? cnt_r - 8'h01 : cnt_r;
    assign o_expired = run_r && (cnt_r == 8'h00);
    assign first_seen = first_r | i_data_done;
    // Zero setting: stop after first data once grant is gone; MWI runs on
    assign o_stop = i_frame_active && i_gnt_n && !i_mwi &&
                    (zero_lat ? first_seen : o_expired);

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt_r <= 8'h00;
            run_r <= 1'b0;
            first_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            run_r <= i_frame_start | (run_r & i_frame_active);
            first_r <= !i_frame_start && i_frame_active && first_seen;
        end
    end
endmodule

// ---- tb/bscr_regs_properties.sv ----
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Port checks
// ----------------------------------------------------------------
module bscr_regs_properties (
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic i_awvalid,
    input wire logic o_awready,
    input wire logic i_wvalid,
    input wire logic o_wready,
    input wire logic o_bvalid,
    input wire logic i_bready,
    input wire logic i_arvalid,
    input wire logic o_arready,
    input wire logic [7:0] i_araddr,
    input wire logic o_rvalid,
    input wire logic i_rready,
    input wire logic [31:0] o_rdata,
    input wire logic i_io_valid,
    input wire logic o_io_forward,
    input wire logic i_frame_active,
    input wire logic i_sec_gnt_n,
    input wire logic i_mwi,
    input wire logic o_master_stop
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);
    property p_rd_lat; i_arvalid && o_arready |=> o_rvalid; endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read answer missing");
    property p_rd_hold; o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data not held");
    property p_ar_block; o_rvalid |-> !o_arready; endproperty
    a_ar_block: assert property (p_ar_block) else $error("read taken while answering");
    property p_wr_resp; i_awvalid && o_awready && i_wvalid && o_wready |-> ##[1:3] o_bvalid;
    endproperty
    a_wr_resp: assert property (p_wr_resp) else $error("write answer missing");
    property p_b_hold; o_bvalid && !i_bready |=> o_bvalid; endproperty
    a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
    property p_fixed; $rose(o_rvalid) && $past(i_araddr) == 8'h1c |-> o_rdata[26:25] == 2'b01
        && o_rdata[23:16] == 8'ha0 && o_rdata[11:8] == 4'h1 && o_rdata[3:0] == 4'h1; endproperty
    a_fixed: assert property (p_fixed) else $error("fixed field wrong");
    property p_fwd_idle; !i_io_valid |=> !o_io_forward; endproperty
    a_fwd_idle: assert property (p_fwd_idle) else $error("forward without cycle");
    property p_stop_off; !i_frame_active || !i_sec_gnt_n || i_mwi |-> !o_master_stop; endproperty
    a_stop_off: assert property (p_stop_off) else $error("stop when not allowed");
endmodule
bind bscr_regs bscr_regs_properties bscr_regs_properties_i (.*);

// ---- tb/bscr_sec_agent.sv ----
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Secondary bus agents
// ----------------------------------------------------------------
module bscr_sec_agent (
    input wire logic i_mclk,
    input wire logic i_master_stop,
    input wire logic i_lat_expired,
    output logic o_perr_n,
    output logic o_serr_n,
    output logic o_ta_sig,
    output logic o_ta_rcv,
    output logic o_ma_rcv,
    output logic o_par_det,
    output logic o_frame_start,
    output logic o_frame_active,
    output logic o_gnt_n,
    output logic o_data_done,
    output logic o_mwi
);
    logic [5:0] ev = 6'h00;
    // Error pins idle high, pulled up on the bus
    assign o_perr_n = !ev[0];
    assign o_serr_n = !ev[4];
    assign {o_par_det, o_ma_rcv, o_ta_rcv, o_ta_sig} = {ev[5], ev[3:1]};
    initial begin
        {o_frame_start, o_frame_active, o_gnt_n, o_data_done, o_mwi} = 5'h00;
    end
    task automatic pulse(input int i);
        @(posedge i_mclk);
        ev[i] <= 1'b1;
        @(posedge i_mclk);
        ev <= 6'h00;
    endtask
    // One data phase; frame held so stop can be seen
    task automatic master(input logic gnt_n, input logic mwi, output logic [1:0] stop);
        @(posedge i_mclk);
        o_frame_start <= 1'b1;
        o_frame_active <= 1'b1;
        o_gnt_n <= gnt_n;
        o_mwi <= mwi;
        @(posedge i_mclk);
        o_frame_start <= 1'b0;
        o_data_done <= 1'b1;
        @(posedge i_mclk);
        o_data_done <= 1'b0;
        @(negedge i_mclk);
        stop = {i_lat_expired, i_master_stop};
        @(posedge i_mclk);
        {o_frame_active, o_gnt_n, o_mwi} <= 3'h0;
    endtask
endmodule

// ---- tb/test_bscr_regs.sv ----
`timescale 1ns/100ps
module test_bscr_regs;
    logic i_mclk = 1'b0, i_rstn = 1'b0;
    logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
    logic i_arvalid = 1'b0, i_rready = 1'b0, i_io_valid = 1'b0;
    logic [7:0] i_awaddr = 8'h00, i_araddr = 8'h00, o_subordinate_bus;
    logic [31:0] i_wdata = 32'h0, i_io_addr = 32'h0, o_rdata, rdat, rnd;
    logic [3:0] i_wstrb = 4'h0;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq;
    logic o_lat_expired, o_master_stop, o_io_forward;
    logic [1:0] o_bresp, o_rresp, wrsp, rrsp, st;
    logic i_secondary_parity_error_pin_n, i_secondary_system_error_pin_n;
    logic i_target_abort_signaled, i_target_abort_received, i_master_abort_received;
    logic i_parity_error_detected, i_frame_start, i_frame_active, i_sec_gnt_n;
    logic i_data_done, i_mwi;
    logic [15:0] io16;
    logic [31:0] pr [6];
    int pos [6] = '{24, 27, 28, 29, 30, 31};
    logic [7:0] lt [5] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'hff};
    logic [1:0] gm [5] = '{2'b10, 2'b00, 2'b11, 2'b10, 2'b10};
    int num_errors = 0;
    int compares = 0;
    always #25 i_mclk = ~i_mclk;
    bscr_regs bscr_regs_i (.*);
    bscr_sec_agent bscr_sec_agent_i (
        .i_mclk, .i_master_stop(o_master_stop), .o_perr_n(i_secondary_parity_error_pin_n),
        .o_serr_n(i_secondary_system_error_pin_n), .o_ta_sig(i_target_abort_signaled),
        .o_ta_rcv(i_target_abort_received), .o_ma_rcv(i_master_abort_received),
        .o_par_det(i_parity_error_detected), .o_frame_start(i_frame_start),
        .o_frame_active(i_frame_active), .o_gnt_n(i_sec_gnt_n), .o_data_done(i_data_done),
        .o_mwi(i_mwi), .i_lat_expired(o_lat_expired)
    );
    function automatic logic [31:0] nx(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [31:0] sts(input logic [15:0] lo, input int p);
        return 32'h02a0_0000 | {16'h0, lo} | ((p > 0) ? (32'h1 << p) : 32'h0);
    endfunction
    function automatic logic [31:0] fwd(input logic [31:0] a);
        return {31'h0, a >= {16'h1, io16[7:4], 12'h000} && a <= {16'h1, io16[15:12], 12'hfff}};
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        int n = 0;
        logic ta, tw, tk = 1'b0, bv;
        @(posedge i_mclk);
        {i_awaddr, i_wdata, i_wstrb} <= {a, d, s};
        {i_awvalid, i_wvalid} <= 2'b11;
        while (!tk && n < 50) begin
            @(negedge i_mclk);
            n++;
            {ta, tw} = {i_awvalid && o_awready, i_wvalid && o_wready};
            {tk, bv, wrsp} = {o_bvalid && i_bready, o_bvalid, o_bresp};
            @(posedge i_mclk);
            if (ta) i_awvalid <= 1'b0;
            if (tw) i_wvalid <= 1'b0;
            if (tk) i_bready <= 1'b0;
            else if (bv) i_bready <= 1'b1;
        end
        if (!tk) num_errors++;
    endtask
    task automatic rd(input logic [7:0] a);
        int n = 0;
        logic ta, tk = 1'b0, rv;
        @(posedge i_mclk);
        i_araddr <= a;
        i_arvalid <= 1'b1;
        while (!tk && n < 50) begin
            @(negedge i_mclk);
            n++;
            {ta, tk, rv} = {i_arvalid && o_arready, o_rvalid && i_rready, o_rvalid};
            {rdat, rrsp} = {o_rdata, o_rresp};
            @(posedge i_mclk);
            if (ta) i_arvalid <= 1'b0;
            if (tk) i_rready <= 1'b0;
            else if (rv) i_rready <= 1'b1;
        end
        if (!tk) num_errors++;
    endtask
    task automatic io(input logic [31:0] a);
        @(posedge i_mclk);
        {i_io_valid, i_io_addr} <= {1'b1, a};
        @(posedge i_mclk);
        i_io_valid <= 1'b0;
        @(negedge i_mclk);
        check({31'h0, o_io_forward}, fwd(a));
    endtask
    task automatic summarize;
        $display("comparisons %0d, mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Twenty times the expected run
    initial begin
        #500000;
        num_errors++;
        summarize();
    end
    initial begin
        rnd = 32'h95b68672;
        io16 = 16'h0101;
        repeat (6) @(posedge i_mclk);
        i_rstn <= 1'b1;
        rd(8'h18);
        check(rdat, 32'h0);
        rd(8'h1c);
        check(rdat, sts(io16, 0));
        $display("test reset done");
        for (int k = 0; k < 6; k++) begin
            rnd = nx(rnd);
            wr(8'h18, rnd, 4'hf);
            check({30'h0, wrsp}, 32'h0);
            wr(8'h18, ~rnd, 4'h4);
            rd(8'h18);
            check(rdat, {rnd[31:24], ~rnd[23:16], 16'h0});
            check({24'h0, o_subordinate_bus}, {24'h0, ~rnd[23:16]});
        end
        $display("test config done");
        wr(8'h80, rnd, 4'hf);
        check({30'h0, wrsp}, 32'h2);
        rd(8'h80);
        check({rrsp, rdat[29:0]}, 32'h8000_0000);
        $display("test unmapped done");
        wr(8'h4c, 32'h0001_0001, 4'hf);
        for (int k = 0; k < 6; k++) begin
            rnd = nx(rnd);
            wr(8'h1c, rnd, 4'h3);
            io16 = {rnd[15:12], 4'h1, rnd[7:4], 4'h1};
            rd(8'h1c);
            check(rdat, sts(io16, 0));
            pr[0] = {16'h1, io16[7:4], 12'h000};
            pr[1] = pr[0] - 32'h1;
            pr[2] = {16'h1, io16[15:12], 12'hfff};
            pr[3] = pr[2] + 32'h1;
            pr[4] = {16'h1, rnd[31:16]};
            pr[5] = {16'h2, rnd[31:16]};
            foreach (pr[j]) io(pr[j]);
        end
        $display("test io window done");
        // Parity pin must be ignored while parity response is off
        bscr_sec_agent_i.pulse(0);
        rd(8'h1c);
        check(rdat, sts(io16, 0));
        rd(8'h40);
        wr(8'h48, 32'h40, 4'h1);
        wr(8'h44, 32'h0, 4'h1);
        bscr_sec_agent_i.pulse(5);
        @(negedge i_mclk);
        check({31'h0, o_irq}, 32'h0);
        rd(8'h40);
        check(rdat, 32'h20);
        wr(8'h1c, 32'h8000_0000, 4'h8);
        wr(8'h44, 32'h3f, 4'h1);
        for (int i = 0; i < 6; i++) begin
            bscr_sec_agent_i.pulse(i);
            @(negedge i_mclk);
            check({31'h0, o_irq}, 32'h1);
            wr(8'h1c, 32'h0, 4'h8);
            rd(8'h1c);
            check(rdat, sts(io16, pos[i]));
            rd(8'h40);
            check(rdat, 32'h1 << i);
            @(negedge i_mclk);
            check({31'h0, o_irq}, 32'h0);
            wr(8'h1c, 32'h1 << pos[i], 4'h8);
            rd(8'h1c);
            check(rdat, sts(io16, 0));
        end
        $display("test events done");
        for (int k = 0; k < 5; k++) begin
            wr(8'h18, {lt[k], 24'h0}, 4'h8);
            bscr_sec_agent_i.master(gm[k][1], gm[k][0], st);
            check({30'h0, st},
                  {30'h0, lt[k] < 8'h02, lt[k] < 8'h02 && gm[k] == 2'b10});
        end
        $display("test latency done");
        summarize();
    end
endmodule
